//--- core/tifa_regs.vh
`ifndef TIFA_REGS_VH
`define TIFA_REGS_VH

// ==========================================================================
// register offsets (byte addresses)
`define TIFA_OFS_NOFC_INTERVAL 12'h000
`define TIFA_OFS_NOFC_LIMIT    12'h004
`define TIFA_OFS_FAIR_BASE     12'h010
`define TIFA_OFS_FAIR_LAST     12'h01c
`define TIFA_OFS_BUCKET_BASE   12'h020
`define TIFA_OFS_BUCKET_LAST   12'h024

// ==========================================================================
// field positions of a fairness status word
`define TIFA_STAT_DENOM_LSB    0
`define TIFA_STAT_WINDOW_LSB   8
`define TIFA_STAT_PRIO_BIT     16

// ==========================================================================
// reset values
`define TIFA_RST_DENOM         8'h01
`define TIFA_RST_WINDOW        8'h01
`define TIFA_RST_LFSR          9'h001
`define TIFA_RST_INTERVAL      16'h0040
`define TIFA_RST_LIMIT         8'h04

// ==========================================================================
// counts
`define TIFA_UNIT_COUNT        32
`define TIFA_UNIT_CNT_MAX      3'h7
`define TIFA_ALT_RUN           3'h4

`endif

//--- core/tifa_arbiter.v
// Summary of operation
// (R01) thirty-two 3-bit per-unit forwarding counters plus one shared 8-bit counter
// (R02) each forwarded packet bumps its unit counter and the shared counter
// (R03) unit counter overflow captures shared count as denominator, clears all counters
// (R04) reset clears counters and sets the denominator to one
// (R05) 8-bit window resets to one, priority flag resets to zero
// (R06) only forwarded pending: send it, decrement window
// (R07) only local pending: send it, clear priority; local always goes when idle
// (R08) both pending: priority set sends local, else forwarded with window decrement
// (R09) window reaching zero reloads window and sets priority
// (R10) 9-bit LFSR x^9+x^4+1 steps once per window reload
// (R11) reload value is (denominator + LFSR low three bits) shifted right three
// (R12) chain-flagged packets are not counted, so a chain counts once
// (R13) info packets bypass fairness pacing entirely
// (R14) independent fairness copy per direction, no software knobs for fairness
// (R15) a packet competes only when ready and a far-end buffer is free; info packets here are granted with no buffer check
// (R16) blocked local packet holds back same-channel forwards while it has priority
// (R17) alternate set beats base set but base still gets turns; own fairness copy
// (R18) no-flow-control channel ranks next after info packets under its bucket limit
// (R19) bucket refills once per interval, saturating at its limit
// (R20) each sent no-flow-control packet takes one from the bucket, floor zero
// (R21) no-flow-control send needs a non-empty bucket; bucket resets to zero
// (R22) LFSR resets to a fixed non-zero seed
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`include "tifa_regs.vh"
`default_nettype none

module tifa_arbiter #(
    parameter [8:0] LFSR_SEED = `TIFA_RST_LFSR
) (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    // per direction (bit 0 upstream, bit 1 downstream)
    input  wire [1:0]  link_slot,
    input  wire [1:0]  info_req,
    input  wire [1:0]  nofc_req,
    input  wire [1:0]  nofc_buf_free,
    output reg  [1:0]  info_grant,
    output reg  [1:0]  nofc_grant,
    // per source set k = 2*direction + set (set 1 is the alternate channel set)
    input  wire [3:0]  fwd_req,
    input  wire [3:0]  fwd_buf_free,
    input  wire [3:0]  fwd_chain,
    input  wire [19:0] fwd_unit_id,
    input  wire [7:0]  fwd_vc,
    input  wire [3:0]  loc_req,
    input  wire [3:0]  loc_buf_free,
    input  wire [3:0]  loc_chain,
    input  wire [7:0]  loc_vc,
    output reg  [3:0]  fwd_grant,
    output reg  [3:0]  loc_grant
);

    // ======================================================================
    // state
    reg  [2:0]  ucnt [0:127];
    reg  [7:0]  fcnt [0:3];
    reg  [7:0]  denom [0:3];
    reg  [7:0]  window [0:3];
    reg  [8:0]  lfsr [0:3];
    reg  [3:0]  prio;
    reg  [7:0]  bucket [0:1];
    reg  [15:0] tick [0:1];
    reg  [2:0]  base_wait [0:1];
    reg  [1:0]  lock;
    reg  [3:0]  lock_src;
    reg  [15:0] nofc_refill_interval;
    reg  [7:0]  nofc_bucket_limit;
    reg         wr_pend;
    reg  [11:0] wr_addr;

    // ======================================================================
    // helpers
    // shifts left with the new bit at the bottom; a non-zero seed never reaches zero
    function [8:0] lfsr_next;
        input [8:0] q;
        begin
            lfsr_next = {q[7:0], q[8] ^ q[3]};
        end
    endfunction

    function [7:0] window_reload;
        input [7:0] dn;
        input [8:0] q;
        reg   [8:0] sum;
        begin
            sum = {1'b0, dn} + {6'h00, q[2:0]};
            window_reload = {2'b00, sum[8:3]};
        end
    endfunction

    // ======================================================================
    // arbitration
    reg  [3:0] set_fwd;
    reg  [3:0] set_loc;
    reg  [3:0] next_fwd_grant;
    reg  [3:0] next_loc_grant;
    reg  [1:0] next_info_grant;
    reg  [1:0] next_nofc_grant;
    reg  [1:0] busy;
    reg  [1:0] base_pend;
    reg        hold;
    reg        f;
    reg        l;
    reg        alt_any;
    integer    k;
    integer    d;

    always @* begin
        hold = 1'b0;
        f = 1'b0;
        l = 1'b0;
        alt_any = 1'b0;
        set_fwd = 4'h0;
        set_loc = 4'h0;
        next_fwd_grant = 4'h0;
        next_loc_grant = 4'h0;
        next_info_grant = 2'b00;
        next_nofc_grant = 2'b00;
        base_pend = 2'b00;
        for (k = 0; k < 4; k = k + 1) begin
            d = k / 2;
            // blocked local packet keeps its buffer from same-channel forwards
            // forwards in other channels still go, so the link does not idle
            hold = prio[k] & loc_req[k] & ~loc_buf_free[k] &
                   (fwd_vc[k*2 +: 2] == loc_vc[k*2 +: 2]);                       // see (R16)
            f = fwd_req[k] & fwd_buf_free[k] & ~hold &
                (~lock[d] | (lock_src[d*2+1] == k[0] && !lock_src[d*2]));    // see (R15)
            // local goes when priority is set or nothing waits to be forwarded
            l = loc_req[k] & loc_buf_free[k] &
                (~lock[d] | (lock_src[d*2+1] == k[0] && lock_src[d*2]));     // see (R15)
            set_loc[k] = l & (prio[k] | ~f);                                 // see (R07) see (R08)
            set_fwd[k] = f & ~set_loc[k];                                    // see (R06) see (R08)
        end
        for (d = 0; d < 2; d = d + 1) begin
            busy[d] = fwd_grant[d*2] | fwd_grant[d*2+1] | loc_grant[d*2] |
                      loc_grant[d*2+1] | nofc_grant[d] | info_grant[d];
            base_pend[d] = set_fwd[d*2] | set_loc[d*2];
            alt_any = set_fwd[d*2+1] | set_loc[d*2+1];
            // a direction decides only while none of its grants is high, so each
            // grant stands one cycle and the far side sees one packet per decision
            if (link_slot[d] && !busy[d]) begin
                // info packets are per link and never wait for the pacing logic
                if (info_req[d]) begin
                    next_info_grant[d] = 1'b1;                               // see (R13)
                // no-flow-control packets may not break into a chain
                end else if (nofc_req[d] && nofc_buf_free[d] && bucket[d] != 8'h00 &&
                             !lock[d]) begin
                    next_nofc_grant[d] = 1'b1;                               // see (R18) see (R21)
                end else if (alt_any && !(base_pend[d] && base_wait[d] >= `TIFA_ALT_RUN)) begin
                    next_fwd_grant[d*2+1] = set_fwd[d*2+1];                  // see (R17)
                    next_loc_grant[d*2+1] = set_loc[d*2+1];
                end else begin
                    next_fwd_grant[d*2] = set_fwd[d*2];
                    next_loc_grant[d*2] = set_loc[d*2];
                end
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fwd_grant  <= 4'h0;
            loc_grant  <= 4'h0;
            info_grant <= 2'b00;
            nofc_grant <= 2'b00;
        end else begin
            // grants come straight from flip-flops so each is a clean pulse
            fwd_grant  <= next_fwd_grant;
            loc_grant  <= next_loc_grant;
            info_grant <= next_info_grant;
            nofc_grant <= next_nofc_grant;
        end
    end

    // ======================================================================
    // chain lock and base-set starvation guard
    // a chain pins its direction to one source until an unchained packet
    // ends it, so no other source set and no no-flow-control packet splits a chained group; info packets still go
    integer c;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock <= 2'b00;
            lock_src <= 4'h0;
            base_wait[0] <= 3'h0;
            base_wait[1] <= 3'h0;
        end else begin
            for (c = 0; c < 2; c = c + 1) begin
                if (next_fwd_grant[c*2] | next_fwd_grant[c*2+1]) begin
                    lock[c] <= next_fwd_grant[c*2] ? fwd_chain[c*2] : fwd_chain[c*2+1];
                    lock_src[c*2 +: 2] <= {next_fwd_grant[c*2+1], 1'b0};
                end else if (next_loc_grant[c*2] | next_loc_grant[c*2+1]) begin
                    lock[c] <= next_loc_grant[c*2] ? loc_chain[c*2] : loc_chain[c*2+1];
                    lock_src[c*2 +: 2] <= {next_loc_grant[c*2+1], 1'b1};
                end
                // the alternate set runs at most the limit over a waiting base set
                if (next_fwd_grant[c*2] | next_loc_grant[c*2]) begin
                    base_wait[c] <= 3'h0;                                    // see (R17)
                end else if ((next_fwd_grant[c*2+1] | next_loc_grant[c*2+1]) &&
                             base_pend[c] && base_wait[c] != 3'h7) begin
                    base_wait[c] <= base_wait[c] + 3'h1;                     // see (R17)
                end
            end
        end
    end

    // ======================================================================
    // fairness copies: rate measurement and insertion pacing
    wire [3:0] fev;
    wire [3:0] lev;
    wire [4:0] uid [0:3];
    integer    n;
    integer    u;
    genvar     gi;

    // chained packets never reach the counters or the window
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_count
            assign fev[gi] = next_fwd_grant[gi] & ~fwd_chain[gi];            // see (R12)
            assign lev[gi] = next_loc_grant[gi] & ~loc_chain[gi];            // see (R12)
            assign uid[gi] = fwd_unit_id[gi*5 +: 5];
        end
    endgenerate

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (n = 0; n < 4; n = n + 1) begin
                for (u = 0; u < `TIFA_UNIT_COUNT; u = u + 1) begin
                    ucnt[n*32+u] <= 3'h0;                                    // see (R04)
                end
                fcnt[n]   <= 8'h00;                                          // see (R04)
                denom[n]  <= `TIFA_RST_DENOM;                                // see (R04)
                window[n] <= `TIFA_RST_WINDOW;                               // see (R05)
                lfsr[n]   <= LFSR_SEED;                                      // see (R22)
            end
            prio <= 4'h0;                                                    // see (R05)
        end else begin
            // four independent copies: base and alternate set of each direction
            for (n = 0; n < 4; n = n + 1) begin                              // see (R14)
                if (fev[n]) begin
                    if (ucnt[n*32+uid[n]] == `TIFA_UNIT_CNT_MAX) begin
                        // the overflowing packet counts in the captured denominator
                        denom[n] <= fcnt[n] + 8'h01;                         // see (R03)
                        fcnt[n] <= 8'h00;
                        for (u = 0; u < `TIFA_UNIT_COUNT; u = u + 1) begin
                            ucnt[n*32+u] <= 3'h0;                            // see (R03)
                        end
                    end else begin
                        ucnt[n*32+uid[n]] <= ucnt[n*32+uid[n]] + 3'h1;       // see (R01) see (R02)
                        fcnt[n] <= fcnt[n] + 8'h01;                          // see (R02)
                    end
                    // the reload is zero when the denominator plus the LFSR low three bits is under eight;
                    // such a window expires at the next counted forward
                    // a window of 0 or 1 expires on this decrement
                    if (window[n] <= 8'h01) begin
                        window[n] <= window_reload(denom[n], lfsr[n]);       // see (R09) see (R11)
                        lfsr[n] <= lfsr_next(lfsr[n]);                       // see (R10)
                        prio[n] <= 1'b1;                                     // see (R09)
                    end else begin
                        window[n] <= window[n] - 8'h01;                      // see (R06)
                    end
                end
                if (lev[n]) begin
                    prio[n] <= 1'b0;                                         // see (R07)
                end
            end
        end
    end

    // ======================================================================
    // no-flow-control leaky bucket
    // a send takes one credit; the refill waits for the interval to run out
    // refill and send on one edge cancel, the bucket does not move
    // the bucket is not clamped when the limit is lowered below it
    integer b;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (b = 0; b < 2; b = b + 1) begin
                bucket[b] <= 8'h00;                                          // see (R21)
                tick[b] <= 16'h0000;
            end
        end else begin
            for (b = 0; b < 2; b = b + 1) begin
                if (tick[b] >= nofc_refill_interval) begin
                    tick[b] <= 16'h0000;
                    if (nofc_grant[b] == 1'b0 && next_nofc_grant[b] &&
                        bucket[b] != 8'h00) begin
                        bucket[b] <= bucket[b];
                    end else if (bucket[b] < nofc_bucket_limit) begin
                        bucket[b] <= bucket[b] + 8'h01;                      // see (R19)
                    end
                end else begin
                    tick[b] <= tick[b] + 16'h0001;
                    if (next_nofc_grant[b] && bucket[b] != 8'h00) begin
                        bucket[b] <= bucket[b] - 8'h01;                      // see (R20)
                    end
                end
            end
        end
    end

    // ======================================================================
    // ahb-lite register slave
    // write data arrive one cycle after the address phase, so the address
    // is kept for the data phase
    // status words are read-only, writes to them are dropped
    // addresses above the block's 4 KB page read as zero
    reg  [31:0] rd_word;
    wire [11:0] a_addr = haddr[11:0];
    wire        a_take = hsel & htrans[1] & hready;
    reg  [1:0]  r;

    always @* begin
        rd_word = 32'h0000_0000;
        r = a_addr[3:2];
        if (a_addr == `TIFA_OFS_NOFC_INTERVAL) begin
            rd_word = {16'h0000, nofc_refill_interval};
        end else if (a_addr == `TIFA_OFS_NOFC_LIMIT) begin
            rd_word = {24'h00_0000, nofc_bucket_limit};
        end else if (a_addr >= `TIFA_OFS_FAIR_BASE && a_addr <= `TIFA_OFS_FAIR_LAST &&
                     a_addr[1:0] == 2'b00) begin
            rd_word[`TIFA_STAT_DENOM_LSB +: 8]  = denom[r];
            rd_word[`TIFA_STAT_WINDOW_LSB +: 8] = window[r];
            rd_word[`TIFA_STAT_PRIO_BIT]        = prio[r];
        end else if (a_addr >= `TIFA_OFS_BUCKET_BASE && a_addr <= `TIFA_OFS_BUCKET_LAST &&
                     a_addr[1:0] == 2'b00) begin
            rd_word = {24'h00_0000, bucket[r[0]]};
        end
        if (haddr[31:12] != 20'h00000) begin
            rd_word = 32'h0000_0000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            wr_pend   <= 1'b0;
            wr_addr   <= 12'h000;
            nofc_refill_interval <= `TIFA_RST_INTERVAL;
            nofc_bucket_limit    <= `TIFA_RST_LIMIT;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= a_take & hwrite & (haddr[31:12] == 20'h00000);
            wr_addr   <= a_addr;
            if (a_take && !hwrite) begin
                hrdata <= rd_word;
            end
            if (wr_pend) begin
                if (wr_addr == `TIFA_OFS_NOFC_INTERVAL) begin
                    nofc_refill_interval <= hwdata[15:0];
                end else if (wr_addr == `TIFA_OFS_NOFC_LIMIT) begin
                    nofc_bucket_limit <= hwdata[7:0];
                end
            end
        end
    end

endmodule

`default_nettype wire

//--- dv/tifa_arbiter_monitor.sv
`default_nettype none
module tifa_arbiter_monitor (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // bus answer
    input wire logic       hreadyout,
    input wire logic       hresp,
    // packet side
    input wire logic [1:0] link_slot,
    input wire logic [1:0] info_req,
    input wire logic [1:0] nofc_req,
    input wire logic [1:0] nofc_buf_free,
    input wire logic [1:0] info_grant,
    input wire logic [1:0] nofc_grant,
    input wire logic [3:0] fwd_req,
    input wire logic [3:0] fwd_buf_free,
    input wire logic [3:0] loc_req,
    input wire logic [3:0] loc_buf_free,
    input wire logic [3:0] fwd_grant,
    input wire logic [3:0] loc_grant
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire [5:0] g0 = {info_grant[0], nofc_grant[0], fwd_grant[1:0], loc_grant[1:0]};
    wire [5:0] g1 = {info_grant[1], nofc_grant[1], fwd_grant[3:2], loc_grant[3:2]};
    // upstream can decide, nothing above or beside the base set pending
    wire idle0 = link_slot[0] & ~(|g0) & ~info_req[0] & ~nofc_req[0] & ~fwd_req[1] & ~loc_req[1];
    sequence s_fwd_only; idle0 && fwd_req[0] && fwd_buf_free[0] && !loc_req[0]; endsequence
    sequence s_loc_only; idle0 && loc_req[0] && loc_buf_free[0] && !fwd_req[0]; endsequence
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not zero-wait okay");
    property p_one_grant; $onehot0(g0) && $onehot0(g1); endproperty
    a_one_grant: assert property (p_one_grant) else $error("two grants at once");
    property p_gap; ((|g0) |=> !(|g0)) and ((|g1) |=> !(|g1)); endproperty
    a_gap: assert property (p_gap) else $error("grants in adjacent cycles");
    property p_slot; ((|g0) -> $past(link_slot[0])) && ((|g1) -> $past(link_slot[1])); endproperty
    a_slot: assert property (p_slot) else $error("grant without link slot");
    property p_fwd_buf; (fwd_grant & ~$past(fwd_req & fwd_buf_free)) == 4'h0; endproperty
    a_fwd_buf: assert property (p_fwd_buf) else $error("forward sent without buffer");
    property p_loc_buf; (loc_grant & ~$past(loc_req & loc_buf_free)) == 4'h0; endproperty
    a_loc_buf: assert property (p_loc_buf) else $error("local sent without buffer");
    property p_nofc_buf; (nofc_grant & ~$past(nofc_req & nofc_buf_free)) == 2'h0; endproperty
    a_nofc_buf: assert property (p_nofc_buf) else $error("nofc sent unasked");
    property p_info_top; link_slot[0] && info_req[0] && !(|g0) |=> info_grant[0]; endproperty
    a_info_top: assert property (p_info_top) else $error("info packet held back");
    property p_fwd_only; s_fwd_only |=> fwd_grant[0]; endproperty
    a_fwd_only: assert property (p_fwd_only) else $error("lone forward not sent");
    property p_loc_only; s_loc_only |=> loc_grant[0]; endproperty
    a_loc_only: assert property (p_loc_only) else $error("lone local not sent");
endmodule

bind tifa_arbiter tifa_arbiter_monitor i_tifa_arbiter_monitor (.hclk, .hresetn, .hreadyout,
    .hresp, .link_slot, .info_req, .nofc_req, .nofc_buf_free, .info_grant, .nofc_grant,
    .fwd_req, .fwd_buf_free, .loc_req, .loc_buf_free, .fwd_grant, .loc_grant);
`default_nettype wire

//--- dv/tifa_far_node.sv
`default_nettype none
module tifa_far_node (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // cycles a buffer stays taken after a packet lands
    input wire logic [1:0] busy_len,
    // packets arriving
    input wire logic [3:0] fwd_grant,
    input wire logic [3:0] loc_grant,
    input wire logic [1:0] nofc_grant,
    // buffer release state
    output logic [3:0]     fwd_buf_free,
    output logic [3:0]     loc_buf_free,
    output logic [1:0]     nofc_buf_free
);
    logic [9:0] sent;
    logic [9:0] free;
    logic [1:0] busy [10];
    assign sent = {nofc_grant, loc_grant, fwd_grant};
    always_ff @(posedge hclk or negedge hresetn) begin
        for (int i = 0; i < 10; i++) begin
            if (!hresetn) busy[i] <= 2'h0;
            else if (sent[i]) busy[i] <= busy_len;
            else if (busy[i] != 2'h0) busy[i] <= busy[i] - 2'h1;
        end
    end
    // a buffer is advertised only once its release has come back
    always_comb begin
        for (int i = 0; i < 10; i++) free[i] = (busy[i] == 2'h0);
    end
    assign {nofc_buf_free, loc_buf_free, fwd_buf_free} = free;
endmodule
`default_nettype wire

//--- dv/tifa_arbiter_tb.sv
`default_nettype none
module tifa_arbiter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0]  htrans, link_slot, info_req, nofc_req, nofc_buf_free, info_grant, nofc_grant;
    logic [1:0]  busy_len;
    logic [2:0]  hsize;
    logic [3:0]  fwd_req, fwd_buf_free, fwd_chain, fwd_grant, loc_req, loc_buf_free, loc_grant;
    logic [3:0]  loc_chain;
    logic [7:0]  fwd_vc, loc_vc;
    logic [19:0] fwd_unit_id;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [4:0]  rq, gv;
    int          num_errors, check_count;
    localparam logic [4:0] G_I = 5'h01, G_N = 5'h02, G_F0 = 5'h04, G_F1 = 5'h08, G_L = 5'h10;
    localparam logic [31:0] RA [9] = '{32'h0, 32'h4, 32'h10, 32'h14, 32'h18, 32'h1c,
        32'h20, 32'h24, 32'h30};
    localparam logic [31:0] RE [9] = '{32'h40, 32'h4, 32'h101, 32'h101, 32'h101, 32'h101,
        32'h0, 32'h0, 32'h0};
    assign gv = {loc_grant[0], fwd_grant[1], fwd_grant[0], nofc_grant[0], info_grant[0]};
    tifa_arbiter i_tifa_arbiter (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .link_slot, .info_req,
        .nofc_req, .nofc_buf_free, .info_grant, .nofc_grant, .fwd_req, .fwd_buf_free,
        .fwd_chain, .fwd_unit_id, .fwd_vc, .loc_req, .loc_buf_free, .loc_chain, .loc_vc,
        .fwd_grant, .loc_grant);
    tifa_far_node i_tifa_far_node (.hclk, .hresetn, .busy_len, .fwd_grant, .loc_grant,
        .nofc_grant, .fwd_buf_free, .loc_buf_free, .nofc_buf_free);
    // ==========================================================================
    // shared tasks
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // raise requests, then judge each grant in turn; keep marks sources with more to send
    task automatic pkts(input logic [4:0] req, input logic [4:0] keep, input logic [19:0] exp,
        input int n);
        int t;
        @(posedge hclk);
        rq = req;
        {loc_req[0], fwd_req[1], fwd_req[0], nofc_req[0], info_req[0]} <= rq;
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(posedge hclk);
                t++;
            end while (gv === 5'h0 && t < 40);
            chk({27'h0, gv}, {27'h0, exp[i*5+:5]});
            rq = (i == n - 1) ? 5'h0 : rq & ~(gv & ~keep);
            {loc_req[0], fwd_req[1], fwd_req[0], nofc_req[0], info_req[0]} <= rq;
        end
    endtask
    task automatic fwd(input logic [4:0] u, input logic c);
        fwd_unit_id[4:0] <= u;
        fwd_chain[0] <= c;
        pkts(G_F0, 5'h0, {15'h0, G_F0}, 1);
    endtask
    // ==========================================================================
    // scenarios
    task automatic t_regs;
        for (int i = 0; i < 9; i++) rd_chk(RA[i], 32'hffffffff, RE[i]);
        ahb(1'b1, 32'h10, 32'hffffffff);
        rd_chk(32'h10, 32'hffffffff, 32'h101);
    endtask
    task automatic t_nofc;
        pkts(G_N | G_F1, 5'h0, {15'h0, G_F1}, 1);
        ahb(1'b1, 32'h4, 32'h2);
        ahb(1'b1, 32'h0, 32'h0);
        repeat (4) @(posedge hclk);
        ahb(1'b1, 32'h0, 32'hffff);
        rd_chk(32'h20, 32'hffffffff, 32'h2);
        rd_chk(32'h0, 32'hffffffff, 32'hffff);
        pkts(G_N | G_F1, G_N, {5'h0, G_F1, G_N, G_N}, 3);
        rd_chk(32'h20, 32'hffffffff, 32'h0);
    endtask
    task automatic t_fair;
        fwd(5'h1, 1'b0);
        rd_chk(32'h10, 32'h1ffff, 32'h10001);
        pkts(G_L, 5'h0, {15'h0, G_L}, 1);
        rd_chk(32'h10, 32'h1ffff, 32'h1);
        pkts(G_I | G_F0 | G_L, 5'h0, {5'h0, G_L, G_F0, G_I}, 3);
        rd_chk(32'h10, 32'h1ffff, 32'h1);
    endtask
    task automatic t_rate;
        busy_len <= 2'h3;
        for (int i = 0; i < 3; i++) fwd(5'h9, 1'b0);
        for (int i = 0; i < 4; i++) fwd(5'h9, 1'b1);
        fwd(5'h9, 1'b0);
        for (int i = 0; i < 8; i++) fwd(5'h5, 1'b0);
        rd_chk(32'h10, 32'hff, 32'he);
        pkts(G_F0 | G_F1, 5'h0, {10'h0, G_F0, G_F1}, 2);
    endtask
    // ==========================================================================
    // clock, reset, sequence and watchdog
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, info_req, nofc_req} = '0;
        {fwd_req, fwd_chain, loc_req, loc_chain, fwd_vc, loc_vc, fwd_unit_id} = '0;
        {busy_len, rq} = '0;
        link_slot = 2'h3;
        hsize = 3'h2;
        num_errors = 0;
        check_count = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_nofc();
        t_fair();
        t_rate();
        complete_run();
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
